/* gfm_defines.svh */
// constants of the two-wire memory target front end
`ifndef GFM_DEFINES_SVH
`define GFM_DEFINES_SVH
`define GFM_MEM_DEPTH       8192
`define GFM_ADDR_W          13
`define GFM_ADDR_RST        13'h0000
`define GFM_BYTE_RST        8'h00
`define GFM_BIT_ACK         4'h8
`define GFM_TYPE_HI         7
`define GFM_TYPE_LO         4
`define GFM_SEL_HI          3
`define GFM_SEL_LO          1
`define GFM_RW_POS          0
`define GFM_AHI_HI          4
`define GFM_SPIKE_NS        50
`define GFM_LINK_PERIOD_PS  12000
`define GFM_SPIKE_CYC       ((`GFM_SPIKE_NS * 1000) / `GFM_LINK_PERIOD_PS)
`endif

/* gfm_pkg.sv */
// types of the two-wire memory target front end
package gfm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA
    } gfm_state_e;
    typedef logic [12:0] gfm_addr_t;
endpackage

/* gfm_sync.sv */
// two-flop synchroniser with optional stability filter
`timescale 1ns/1ps
module gfm_sync
    import gfm_pkg::*;
#(
    parameter int          W    = 1,
    parameter int          FILT = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] last_r;
    logic [3:0]   cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    // output moves only after FILT equal samples (two when FILT is 1), so shorter spikes never reach it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_r <= INIT;
            cnt_r  <= 4'h0;
            q      <= INIT;
        end else begin
            last_r <= sync_r;
            if (sync_r != last_r) begin
                cnt_r <= 4'h1;
            end else if (cnt_r < 4'(FILT)) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (sync_r == last_r && cnt_r >= 4'(FILT - 1)) begin
                q <= sync_r;
            end
        end
    end
endmodule

/* gfm_mem.sv */
// byte-wide storage array with registered read
`timescale 1ns/1ps
`include "gfm_defines.svh"
module gfm_mem
    import gfm_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      we,
    input  wire gfm_addr_t waddr,
    input  wire logic [7:0] wdata,
    input  wire gfm_addr_t raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:`GFM_MEM_DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

/* gfm_target.sv */
// two-wire serial target front end of a byte-wide nonvolatile memory
// How it works
// [R1] 8192 bytes, read and written over serial
// [R2] respond only when select code matches straps
// [R3] open select pins read low via pad
// [R4] data line: pull low or release only
// [R5] sample on clock rise, drive after fall
// [R6] write-lock high blocks every array write
// [R7] reads served whatever the write-lock level
// [R8] open write-lock pin reads low, writes allowed
// [R9] never starts transfers; drives only once addressed
// [R10] master starts transfers and makes the clock
// [R11] master addresses the target before any exchange
// [R12] data changes only while clock low
// [R13] start: data falls while clock high
// [R14] stop during read ends it, back to standby
// [R15] stop during write ends it, back to standby
// [R16] no programming wait after a write stop
// [R17] ninth clock: receiver pulls low to acknowledge
// [R18] direction bit: 0 write, 1 read
// [R19] two address bytes, each acknowledged, then data
// [R20] address steps by one, wraps to zero
// [R21] inputs synchronised and deglitched before decoding
`timescale 1ns/1ps
`include "gfm_defines.svh"
module gfm_target
    import gfm_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = 4'h6  // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       sample_clk,
    input  wire logic       scl,
    input  wire logic       sda_i,
    input  wire logic [2:0] device_select_pins,
    input  wire logic       write_lock,
    output logic            sda_o,
    output logic            sda_oe,
    output logic            standby
);
    ////////////////////////////////////////////////////////////////////
    // system clock side: straps caught, standby reported
    logic [3:0] straps_s;
    logic [3:0] straps_r;
    logic       idle_s;
    logic       idle_r;

    // open pins are pulled low in the pad, so they arrive here as 0
    gfm_sync #(.W(4), .FILT(1), .INIT(4'h0)) u_strap_sync ( // R3 R8
        .clk (clk),
        .rst (sys_rst),
        .d   ({write_lock, device_select_pins}),
        .q   (straps_s)
    );

    gfm_sync #(.W(1), .FILT(1), .INIT(1'b1)) u_idle_sync (
        .clk (clk),
        .rst (sys_rst),
        .d   (idle_r),
        .q   (idle_s)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            straps_r <= 4'h0;
            standby  <= 1'b1;
        end else begin
            straps_r <= straps_s;
            standby  <= idle_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link side: pins and straps brought into the sample clock
    logic [3:0] straps_l;
    logic       scl_f;
    logic       sda_f;
    logic       scl_q;
    logic       sda_q;
    logic       wp_l;
    logic [2:0] sel_l;

    gfm_sync #(.W(4), .FILT(1), .INIT(4'h0)) u_strap_xing (
        .clk (sample_clk),
        .rst (sys_rst),
        .d   (straps_r),
        .q   (straps_l)
    );

    gfm_sync #(.W(2), .FILT(`GFM_SPIKE_CYC), .INIT(2'b11)) u_bus_sync ( // R21
        .clk (sample_clk),
        .rst (sys_rst),
        .d   ({scl, sda_i}),
        .q   ({scl_f, sda_f})
    );

    assign wp_l  = straps_l[3];
    assign sel_l = straps_l[2:0];

    always_ff @(posedge sample_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;

    assign start_ev = scl_f & scl_q & sda_q & ~sda_f; // R13
    assign stop_ev  = scl_f & scl_q & ~sda_q & sda_f; // R14 R15
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;

    ////////////////////////////////////////////////////////////////////
    // protocol engine
    gfm_state_e state_r;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r;
    logic       ack_phase_r;
    gfm_addr_t  addr_r;
    logic [7:0] rdata;
    logic       mem_we;
    logic       receiving;
    logic       decide;
    logic       match;

    assign receiving = (state_r == ST_DEVADDR) || (state_r == ST_ADDR_HI)
                    || (state_r == ST_ADDR_LO) || (state_r == ST_WDATA);
    assign decide    = scl_fall && receiving && !ack_phase_r
                    && (bitcnt_r == `GFM_BIT_ACK);
    assign match     = (shift_r[`GFM_TYPE_HI:`GFM_TYPE_LO] == TYPE_CODE)
                    && (shift_r[`GFM_SEL_HI:`GFM_SEL_LO] == sel_l); // R2
    assign mem_we    = decide && (state_r == ST_WDATA) && !wp_l; // R6

    gfm_mem u_mem ( // R1
        .clk   (sample_clk),
        .we    (mem_we),
        .waddr (addr_r),
        .wdata (shift_r),
        .raddr (addr_r),
        .rdata (rdata)
    );

    always_ff @(posedge sample_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r     <= ST_IDLE;
            bitcnt_r    <= 4'h0;
            shift_r     <= `GFM_BYTE_RST;
            ack_phase_r <= 1'b0;
            sda_oe      <= 1'b0;
            addr_r      <= `GFM_ADDR_RST;
        end else if (stop_ev) begin
            // standby at once: no write wait, next start is taken
            state_r     <= ST_IDLE; // R14 R15 R16
            ack_phase_r <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (start_ev) begin
            // a repeated start restarts framing but keeps the address
            state_r     <= ST_DEVADDR; // R13 R9
            bitcnt_r    <= 4'h0;
            ack_phase_r <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (scl_rise && receiving) begin
            if (bitcnt_r < `GFM_BIT_ACK) begin
                shift_r  <= {shift_r[6:0], sda_f}; // R5
                bitcnt_r <= bitcnt_r + 4'h1;
            end else begin
                bitcnt_r <= 4'h0;
            end
        end else if (scl_rise && state_r == ST_RDATA) begin
            if (bitcnt_r < `GFM_BIT_ACK) begin
                bitcnt_r <= bitcnt_r + 4'h1;
            end else begin
                bitcnt_r <= 4'h0;
                if (sda_f) begin
                    state_r <= ST_IDLE; // R17
                end
            end
        end else if (decide) begin
            ack_phase_r <= 1'b1;
            sda_oe      <= 1'b1; // R17
            case (state_r)
                ST_DEVADDR: begin
                    if (!match) begin
                        state_r     <= ST_IDLE; // R2
                        ack_phase_r <= 1'b0;
                        sda_oe      <= 1'b0;
                    end else if (shift_r[`GFM_RW_POS]) begin
                        state_r <= ST_RDATA; // R18 R7
                    end else begin
                        state_r <= ST_ADDR_HI; // R18
                    end
                end
                ST_ADDR_HI: begin
                    addr_r[12:8] <= shift_r[`GFM_AHI_HI:0]; // R19
                    state_r      <= ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    addr_r[7:0] <= shift_r; // R19
                    state_r     <= ST_WDATA;
                end
                ST_WDATA: begin
                    // locked bytes are still acknowledged, only not stored
                    addr_r <= addr_r + 13'h0001; // R20
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end else if (scl_fall && ack_phase_r) begin
            ack_phase_r <= 1'b0;
            bitcnt_r    <= 4'h0;
            if (state_r == ST_RDATA) begin
                shift_r <= rdata;
                sda_oe  <= ~rdata[7]; // R5 R4
            end else begin
                sda_oe <= 1'b0;
            end
        end else if (scl_fall && state_r == ST_RDATA) begin
            if (bitcnt_r == 4'h0) begin
                shift_r <= rdata;
                sda_oe  <= ~rdata[7]; // R5 R4
            end else if (bitcnt_r < `GFM_BIT_ACK) begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe  <= ~shift_r[6]; // R12
            end else begin
                sda_oe <= 1'b0; // R17
                addr_r <= addr_r + 13'h0001; // R20
            end
        end
    end

    always_ff @(posedge sample_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_o  <= 1'b0;
            idle_r <= 1'b1;
        end else begin
            sda_o  <= 1'b0; // R4
            idle_r <= (state_r == ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_idle_quiet: assert property (@(posedge sample_clk) disable iff (sys_rst) // R9
        (state_r == ST_IDLE) |-> !sda_oe)
        else $error("data line driven while idle");

    a_stop_standby: assert property (@(posedge sample_clk) disable iff (sys_rst) // R14
        stop_ev |=> (state_r == ST_IDLE) && !sda_oe ##1 idle_r)
        else $error("stop did not return to standby");

    a_start_frame: assert property (@(posedge sample_clk) disable iff (sys_rst) // R13
        (start_ev && !stop_ev) |=> (state_r == ST_DEVADDR) && (bitcnt_r == 4'h0))
        else $error("start did not open a frame");

    a_drive_clk_low: assert property (@(posedge sample_clk) disable iff (sys_rst) // R12
        $rose(sda_oe) |-> !scl_f)
        else $error("data line pulled while clock high");

    a_sample_rise: assert property (@(posedge sample_clk) disable iff (sys_rst) // R5
        (scl_rise && receiving && !start_ev && !stop_ev && bitcnt_r < 4'h8)
        |=> shift_r[0] == $past(sda_f) && bitcnt_r == $past(bitcnt_r) + 4'h1)
        else $error("bit not sampled on rising clock");

    a_lock_blocks: assert property (@(posedge sample_clk) disable iff (sys_rst) // R6
        (decide && state_r == ST_WDATA && wp_l)
        |=> u_mem.mem[$past(addr_r)] == $past(u_mem.mem[addr_r]))
        else $error("write while locked");

    a_nomatch_idle: assert property (@(posedge sample_clk) disable iff (sys_rst) // R2
        (decide && state_r == ST_DEVADDR && !match) |=> state_r == ST_IDLE && !sda_oe)
        else $error("foreign select code answered");

    a_addr_wrap: assert property (@(posedge sample_clk) disable iff (sys_rst) // R20
        (decide && state_r == ST_WDATA) |=> addr_r == $past(addr_r) + 13'h0001)
        else $error("address did not advance");

    a_ack_release: assert property (@(posedge sample_clk) disable iff (sys_rst) // R17
        (ack_phase_r && scl_fall && !stop_ev && !start_ev && state_r != ST_RDATA)
        |=> !sda_oe && !ack_phase_r)
        else $error("acknowledge not released after ninth clock");

    a_read_any_lock: assert property (@(posedge sample_clk) disable iff (sys_rst) // R7
        (decide && state_r == ST_DEVADDR && match && shift_r[0]) |=> state_r == ST_RDATA)
        else $error("read refused");

    c_write_byte: cover property (@(posedge sample_clk) disable iff (sys_rst)
        mem_we);
    c_read_byte: cover property (@(posedge sample_clk) disable iff (sys_rst)
        state_r == ST_RDATA && scl_fall && bitcnt_r == 4'h8);
    c_locked_write: cover property (@(posedge sample_clk) disable iff (sys_rst)
        decide && state_r == ST_WDATA && wp_l);
    c_stop_in_write: cover property (@(posedge sample_clk) disable iff (sys_rst)
        stop_ev && state_r == ST_WDATA);
endmodule

/* gfm_master.sv */
// two-wire bus master model that owns the serial clock
`timescale 1ns/1ps
module gfm_master (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_m
);
    // extra low-phase cycles per bit, to play a slow master
    int stretch = 0;

    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // enters and leaves with the clock low
    task automatic bit_slot(input logic b, output logic seen);
        hold(3 + stretch);
        sda_m = b;
        hold(2);
        scl = 1'b1;
        hold(2);
        seen = sda_line;
        hold(3);
        scl = 1'b0;
    endtask

    task automatic start();
        hold(2);
        sda_m = 1'b1;
        hold(2);
        scl = 1'b1;
        hold(3);
        sda_m = 1'b0;
        hold(3);
        scl = 1'b0;
    endtask

    task automatic stop();
        hold(2);
        sda_m = 1'b0;
        hold(2);
        scl = 1'b1;
        hold(3);
        sda_m = 1'b1;
        hold(3);
    endtask

    // a pulse shorter than the input filter must not read as a start
    task automatic spike();
        sda_m = 1'b0;
        #20;
        sda_m = 1'b1;
    endtask

    // device byte always goes first, so a target is selected before any exchange
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], s);
        end
        bit_slot(1'b1, ack);
    endtask

    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            d[i] = s;
        end
        bit_slot(nack, s);
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the two-wire memory target front end
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] TYPE = 4'h6;
    logic       clk;
    logic       sys_rst;
    logic       sample_clk;
    logic       scl;
    logic       sda_m;
    logic       sda_i;
    logic       write_lock;
    logic       sda_o;
    logic       sda_oe;
    logic       standby;
    logic       prev_oe = 1'b0;
    logic [2:0] straps;
    int         miscompares = 0;
    int         checks = 0;

    // pulled-up wire: anyone may pull low
    assign sda_i = sda_m & ~sda_oe;

    gfm_target #(.TYPE_CODE(TYPE)) dut (
        .clk                (clk),
        .sys_rst            (sys_rst),
        .sample_clk         (sample_clk),
        .scl                (scl),
        .sda_i              (sda_i),
        .device_select_pins (straps),
        .write_lock         (write_lock),
        .sda_o              (sda_o),
        .sda_oe             (sda_oe),
        .standby            (standby)
    );

    gfm_master m (
        .clk      (clk),
        .sda_line (sda_i),
        .scl      (scl),
        .sda_m    (sda_m)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        sample_clk = 1'b0;
        #3;
        forever #6 sample_clk = ~sample_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // device output may only move while the clock is low
    always @(negedge clk) begin
        if (sda_oe === 1'b1) check("data out level", {7'h0, sda_o}, 8'h00);
        if (scl === 1'b1 && sys_rst === 1'b0) check("drive in clock high", {7'h0, sda_oe}, {7'h0, prev_oe});
        prev_oe <= sda_oe;
    end

    task automatic wait_standby();
        int n = 0;
        while (standby !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (standby !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic dev(input logic [7:0] b, input logic exp);
        logic a;
        m.start();
        m.wbyte(b, a);
        check("select ack", {7'h0, a}, {7'h0, exp});
    endtask

    task automatic set_addr(input logic [12:0] a);
        logic k;
        dev({TYPE, straps, 1'b0}, 1'b0);
        m.wbyte({3'h0, a[12:8]}, k);
        check("addr hi ack", {7'h0, k}, 8'h00);
        m.wbyte(a[7:0], k);
        check("addr lo ack", {7'h0, k}, 8'h00);
    endtask

    task automatic wr(input logic [7:0] d);
        logic k;
        m.wbyte(d, k);
        check("data ack", {7'h0, k}, 8'h00);
    endtask

    task automatic rd(input logic last, input logic [7:0] exp);
        logic [7:0] d;
        m.rbyte(last, d);
        check("read data", d, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_write_wrap();
        set_addr(13'h1FFF);
        check("busy", {7'h0, standby}, 8'h00);
        wr(8'hC3);
        wr(8'h3C);
        m.stop();
        set_addr(13'h1FFF);
        dev({TYPE, straps, 1'b1}, 1'b0);
        rd(1'b0, 8'hC3);
        rd(1'b1, 8'h3C);
        m.stop();
        wait_standby();
    endtask

    task automatic t_lock();
        m.stretch = 3;
        set_addr(13'h0010);
        wr(8'h5A);
        wr(8'h66);
        m.stop();
        wait_standby();
        write_lock = 1'b1;
        set_addr(13'h0010);
        wr(8'hA5);
        m.stop();
        set_addr(13'h0010);
        dev({TYPE, straps, 1'b1}, 1'b0);
        rd(1'b1, 8'h5A);
        m.stop();
        dev({TYPE, straps, 1'b1}, 1'b0);
        rd(1'b1, 8'h66);
        m.stop();
        write_lock = 1'b0;
        m.stretch = 0;
    endtask

    task automatic t_select();
        for (int i = 0; i < 8; i++) begin
            straps = i[2:0];
            m.hold(20);
            dev({TYPE, i[2:0], 1'b0}, 1'b0);
            m.stop();
            dev({TYPE, i[2:0] ^ 3'h2, 1'b0}, 1'b1);
            m.stop();
        end
        dev({4'h5, straps, 1'b0}, 1'b1);
        m.stop();
    endtask

    // bus idle, clock high: a short dip on data must not open a frame
    task automatic t_spike();
        m.hold(10);
        m.spike();
        m.hold(10);
        check("standby after spike", {7'h0, standby}, 8'h01);
    endtask

    initial begin
        sys_rst = 1'b1;
        write_lock = 1'b0;
        straps = 3'h5;
        repeat (12) @(negedge clk);
        check("standby in reset", {7'h0, standby}, 8'h01);
        check("drive in reset", {7'h0, sda_oe}, 8'h00);
        sys_rst = 1'b0;
        repeat (15) @(negedge clk);
        check("drive after reset", {7'h0, sda_oe}, 8'h00);
        t_write_wrap();
        t_lock();
        t_select();
        t_spike();
        print_verdict();
    end
endmodule
